/* include/adcsc_pkg.sv */
// Package for the converter scan and result control block.
// Assumes a single 200 MHz core clock and an APB register bus with 32-bit data.
package adcsc_pkg;

	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PIN_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_RESULT = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;

	// Converter geometry.
	localparam int RAW_W = 10;
	localparam int RES_W = 16;
	localparam int CH_W = 5;
	localparam int NUM_LOW_CH = 24;
	localparam logic [CH_W-1:0] LAST_LOW_CH = 5'h17;
	localparam logic [CH_W-1:0] SCAN_LEN = 5'h04;
	localparam logic [CH_W-1:0] LAST_SCAN_START = 5'h14;

	// Control register fields.
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_SCAN_BIT = 1;
	localparam int CTRL_CH_LSB = 8;

	// Status register fields.
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_OVR_BIT = 2;
	localparam int STAT_CH_LSB = 8;

	// Reset values and the result padding.
	localparam logic [CH_W-1:0] PIN_CONFIG_RST = 5'h00;
	localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
	localparam logic [5:0] RESULT_PAD = 6'h00;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT,
		ST_WAIT
	} adcsc_state_type;

endpackage : adcsc_pkg

/* core/adcsc_top.sv */
// Converter control: channel assignment, left-justified result and four-channel scan.
// Assumes an external analog core with a start/done handshake on the core clock,
// and an APB master plus a transfer controller on the same clock.
//
// How it works
// - Analog channels form one ascending run.
// - Result left-justified, bits fifteen down six.
// - Scan converts four consecutive low channels.
// - One result register, each conversion overwrites.
// - Transfer controller request per completed result.
//
// Register map, one aligned 32-bit word per register.
// The control word at offset zero holds a write-one start bit in bit zero.
// Bit one of the control word selects scan mode when it is set.
// Bits twelve to eight of the control word hold the first channel.
// A first channel above the last low channel is clamped to that channel.
// In scan mode the first channel is clamped further so that four fit.
// The pin configuration word holds the count of analog channels.
// A count above twenty-four is clamped to twenty-four.
// The result word is read only and holds the justified sample in bits 15 to 0.
// The status word reports busy, done, overrun and the current channel.
// Writing one to done or overrun in the status word clears that flag.
// Any other offset answers with an error and reads as zero.
//
// Bus timing.
// Every access is answered one cycle after its first access edge.
// Ready and error stand for exactly one cycle; read data holds until the next access.
// Back-to-back transfers are accepted with no extra idle cycle.
// The registered answer costs one wait state but keeps the outputs glitch free.
//
// Conversion timing.
// A start write launches the first start pulse one edge later.
// The analog core answers each start with one done pulse and its sample.
// Done is only taken while a conversion is outstanding.
// The completion pulse and the transfer request follow done by one edge.
// In scan mode the next start follows each completion by one edge.
// A start write while busy is ignored, which keeps the channel order intact.
//
// Result handling.
// There is only one result register, so every channel overwrites it.
// The reader must fetch it between two completions of a scan.
// A result overwritten before it was read raises the sticky overrun flag.
// A bus read of the result or a transfer acknowledge clears done.
// When a new completion meets a clear in one cycle, the completion wins.
// The transfer request stays up until it is acknowledged.
// A second completion before the acknowledge keeps the request up.
//
// Pin assignment.
// The analog pins are enabled from channel zero upwards by a single count.
// A gap in the analog run therefore cannot be configured at all.
// The pin enables are registered so the pin muxes see clean levels.
//
// Clocking and reset.
// Everything runs on the core clock; the analog core shares that clock.
// The clock enable freezes every flip-flop, outputs included.
// The asynchronous reset clears every register to its idle value.
// No input crosses a clock domain, so no synchroniser is needed.
//
// Limitations.
// Only the lower twenty-four channels are covered by this block.
// The sample rate is set by the analog core's done timing and the sequencer's wait state between scan conversions.
// Overrun is reported but the lost sample cannot be recovered.
//
// Observability.
// Every output comes straight from a flip-flop for easy checking.
// A port checker may watch the bus, converter and pin outputs.
// No output depends combinationally on any input.
//
// Encoding.
// The sequencer state is an enum so the tool may choose its encoding.
module adcsc_top (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic conv_start_o,
	output logic [4:0] conv_channel_o,
	input wire logic conv_done_i,
	input wire logic [9:0] conv_data_i,
	output logic [23:0] analog_pin_en_o,
	output logic conv_complete_o,
	output logic dtc_req_o,
	input wire logic dtc_ack_i
);

	// Bus, control and converter state.
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic scan_mode_q, scan_mode_d;
	logic [4:0] start_ch_q, start_ch_d;
	logic [4:0] pin_cfg_q, pin_cfg_d;
	logic [15:0] result_q, result_d;
	logic done_q, done_d;
	logic ovr_q, ovr_d;
	logic unread_q, unread_d;
	logic [4:0] cur_ch_q, cur_ch_d;
	logic [4:0] scan_cnt_q, scan_cnt_d;
	logic start_q, start_d;
	logic complete_q, complete_d;
	logic dtc_q, dtc_d;
	logic [23:0] pin_en_q, pin_en_d;
	adcsc_pkg::adcsc_state_type state_q, state_d;

	logic wr_acc;
	logic rd_acc;
	logic start_req;
	logic conv_fire;
	logic [4:0] scan_first;

	// Left-justify a raw sample into the result register layout.
	function automatic logic [15:0] justify(input logic [9:0] raw);
		justify = {raw, adcsc_pkg::RESULT_PAD};
	endfunction : justify

	// Clamp a scan start so the four channels stay inside the low range.
	function automatic logic [4:0] clamp_start(input logic [4:0] ch);
		clamp_start = (ch > adcsc_pkg::LAST_SCAN_START) ? adcsc_pkg::LAST_SCAN_START : ch;
	endfunction : clamp_start

	assign wr_acc = psel_i & penable_i & pwrite_i & ~pready_q;
	assign rd_acc = psel_i & penable_i & ~pwrite_i & ~pready_q;
	assign start_req = wr_acc && (paddr_i == adcsc_pkg::ADDR_CTRL)
		&& pwdata_i[adcsc_pkg::CTRL_START_BIT];
	assign conv_fire = (state_q == adcsc_pkg::ST_CONVERT) && conv_done_i;
	assign scan_first = clamp_start(start_ch_d);

	// Pin enables: a contiguous run from channel zero up to the configured count.
	// A single count field makes a gap in the analog run impossible by construction.
	genvar gi;
	generate
		for (gi = 0; gi < adcsc_pkg::NUM_LOW_CH; gi++) begin : g_pin
			assign pin_en_d[gi] = (5'(gi) < pin_cfg_q);
		end
	endgenerate

	// APB slave: one wait state, answers every access on the second access cycle.
	always_comb begin
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		scan_mode_d = scan_mode_q;
		start_ch_d = start_ch_q;
		pin_cfg_d = pin_cfg_q;
		if (psel_i && penable_i && !pready_q) begin
			pready_d = 1'b1;
			prdata_d = 32'h0000_0000;
			case (paddr_i)
				adcsc_pkg::ADDR_CTRL: begin
					prdata_d[adcsc_pkg::CTRL_SCAN_BIT] = scan_mode_q;
					prdata_d[adcsc_pkg::CTRL_CH_LSB +: 5] = start_ch_q;
				end
				adcsc_pkg::ADDR_PIN_CONFIG: begin
					prdata_d[4:0] = pin_cfg_q;
				end
				adcsc_pkg::ADDR_RESULT: begin
					prdata_d[15:0] = result_q;
				end
				adcsc_pkg::ADDR_STATUS: begin
					prdata_d[adcsc_pkg::STAT_BUSY_BIT] = (state_q != adcsc_pkg::ST_IDLE);
					prdata_d[adcsc_pkg::STAT_DONE_BIT] = done_q;
					prdata_d[adcsc_pkg::STAT_OVR_BIT] = ovr_q;
					prdata_d[adcsc_pkg::STAT_CH_LSB +: 5] = cur_ch_q;
				end
				default: begin
					pslverr_d = 1'b1;
				end
			endcase
			if (pwrite_i) begin
				// Writes answer with the addressed word; unmapped ones read zero.
				if (paddr_i == adcsc_pkg::ADDR_CTRL) begin
					scan_mode_d = pwdata_i[adcsc_pkg::CTRL_SCAN_BIT];
					start_ch_d = (pwdata_i[adcsc_pkg::CTRL_CH_LSB +: 5] > adcsc_pkg::LAST_LOW_CH)
						? adcsc_pkg::LAST_LOW_CH : pwdata_i[adcsc_pkg::CTRL_CH_LSB +: 5];
				end else if (paddr_i == adcsc_pkg::ADDR_PIN_CONFIG) begin
					pin_cfg_d = (pwdata_i[4:0] > 5'(adcsc_pkg::NUM_LOW_CH))
						? 5'(adcsc_pkg::NUM_LOW_CH) : pwdata_i[4:0];
				end else if (paddr_i != adcsc_pkg::ADDR_STATUS) begin
					pslverr_d = 1'b1;
				end
			end
		end
	end

	// Conversion sequencer and the single result register.
	always_comb begin
		state_d = state_q;
		cur_ch_d = cur_ch_q;
		scan_cnt_d = scan_cnt_q;
		start_d = 1'b0;
		complete_d = 1'b0;
		dtc_d = dtc_q & ~dtc_ack_i;
		result_d = result_q;
		done_d = done_q;
		ovr_d = ovr_q;
		unread_d = unread_q;
		// Reading the result by bus or by the transfer controller clears unread and done.
		if ((rd_acc && paddr_i == adcsc_pkg::ADDR_RESULT) || (dtc_q && dtc_ack_i)) begin
			unread_d = 1'b0;
			done_d = 1'b0;
		end
		// Writing one to the done or overrun status bit clears it.
		if (wr_acc && paddr_i == adcsc_pkg::ADDR_STATUS) begin
			if (pwdata_i[adcsc_pkg::STAT_DONE_BIT]) begin
				done_d = 1'b0;
			end
			if (pwdata_i[adcsc_pkg::STAT_OVR_BIT]) begin
				ovr_d = 1'b0;
			end
		end
		case (state_q)
			adcsc_pkg::ST_IDLE: begin
				if (start_req) begin
					cur_ch_d = scan_mode_d ? scan_first : start_ch_d;
					scan_cnt_d = adcsc_pkg::SCAN_LEN - 5'h01;
					if (!scan_mode_d) begin
						scan_cnt_d = 5'h00;
					end
					start_d = 1'b1;
					state_d = adcsc_pkg::ST_CONVERT;
				end
			end
			adcsc_pkg::ST_CONVERT: begin
				if (conv_fire) begin
					result_d = justify(conv_data_i);
					ovr_d = ovr_d | unread_q;
					unread_d = 1'b1;
					done_d = 1'b1;
					complete_d = 1'b1;
					dtc_d = 1'b1;
					state_d = (scan_cnt_q == 5'h00) ? adcsc_pkg::ST_IDLE : adcsc_pkg::ST_WAIT;
				end
			end
			adcsc_pkg::ST_WAIT: begin
				cur_ch_d = cur_ch_q + 5'h01;
				scan_cnt_d = scan_cnt_q - 5'h01;
				start_d = 1'b1;
				state_d = adcsc_pkg::ST_CONVERT;
			end
			default: begin
				state_d = adcsc_pkg::ST_IDLE;
			end
		endcase
	end

	// Registers; the clock enable freezes every flip-flop.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			scan_mode_q <= 1'b0;
			start_ch_q <= 5'h00;
			pin_cfg_q <= adcsc_pkg::PIN_CONFIG_RST;
			result_q <= adcsc_pkg::RESULT_RST;
			done_q <= 1'b0;
			ovr_q <= 1'b0;
			unread_q <= 1'b0;
			cur_ch_q <= 5'h00;
			scan_cnt_q <= 5'h00;
			start_q <= 1'b0;
			complete_q <= 1'b0;
			dtc_q <= 1'b0;
			pin_en_q <= 24'h00_0000;
			state_q <= adcsc_pkg::ST_IDLE;
		end else if (clk_en_i) begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			scan_mode_q <= scan_mode_d;
			start_ch_q <= start_ch_d;
			pin_cfg_q <= pin_cfg_d;
			result_q <= result_d;
			done_q <= done_d;
			ovr_q <= ovr_d;
			unread_q <= unread_d;
			cur_ch_q <= cur_ch_d;
			scan_cnt_q <= scan_cnt_d;
			start_q <= start_d;
			complete_q <= complete_d;
			dtc_q <= dtc_d;
			pin_en_q <= pin_en_d;
			state_q <= state_d;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign conv_start_o = start_q;
	assign conv_channel_o = cur_ch_q;
	assign analog_pin_en_o = pin_en_q;
	assign conv_complete_o = complete_q;
	assign dtc_req_o = dtc_q;

endmodule : adcsc_top

/* tb/adcsc_monitor.sv */
// Port checker for the converter control block.
// Assumes clk_en_i is held high by the bench.
module adcsc_monitor (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic conv_start_o,
	input wire logic [4:0] conv_channel_o,
	input wire logic conv_done_i,
	input wire logic [23:0] analog_pin_en_o,
	input wire logic conv_complete_o,
	input wire logic dtc_req_o,
	input wire logic dtc_ack_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Bus answers and padding are checked against their causes, pin runs for contiguity only.
	apb_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
		else $error("bus answer timing wrong");
	result_pad_a: assert property (pready_o && paddr_i == adcsc_pkg::ADDR_RESULT
		|-> prdata_o[5:0] == 6'h00 && prdata_o[31:16] == 16'h0000) else $error("result pad");
	bad_addr_a: assert property (pready_o && paddr_i > adcsc_pkg::ADDR_STATUS
		|-> pslverr_o && prdata_o == 32'h00000000) else $error("unmapped answer");
	done_resp_a: assert property (conv_done_i |=> conv_complete_o && dtc_req_o)
		else $error("no completion");
	cmpl_pulse_a: assert property (conv_complete_o |=> !conv_complete_o)
		else $error("completion too long");
	req_hold_a: assert property (dtc_req_o && !dtc_ack_i |=> dtc_req_o)
		else $error("request dropped");
	scan_step_a: assert property (conv_complete_o ##1 conv_start_o
		|-> conv_channel_o == $past(conv_channel_o) + 5'h01) else $error("scan step");
	pin_run_a: assert property ((analog_pin_en_o & (analog_pin_en_o + 24'h000001)) == 24'h000000)
		else $error("pin run broken");
	// Main scenarios seen.
	cover property (conv_complete_o ##1 conv_start_o);
	cover property (pslverr_o);
	cover property (dtc_req_o && dtc_ack_i);
endmodule : adcsc_monitor

bind adcsc_top adcsc_monitor mon_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .conv_start_o(conv_start_o),
	.conv_channel_o(conv_channel_o), .conv_done_i(conv_done_i), .dtc_ack_i(dtc_ack_i),
	.analog_pin_en_o(analog_pin_en_o), .conv_complete_o(conv_complete_o), .dtc_req_o(dtc_req_o));

/* tb/adcsc_analog_model.sv */
// Analog source model: answers each start with a sample after a set delay.
// Assumes start pulses on the core clock; data is scrambled outside done.
module adcsc_analog_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [3:0] delay_i,
	input wire logic [9:0] sample_i,
	output logic done_o,
	output logic [9:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Only the done cycle carries the sample, so a late capture shows up.
	initial begin
		done_o = 1'h0;
		data_o = 10'h155;
		forever begin
			@(posedge clk_i);
			if (start_i) begin
				repeat (delay_i) @(posedge clk_i);
				done_o <= 1'h1;
				data_o <= sample_i;
				@(posedge clk_i);
				done_o <= 1'h0;
				data_o <= ~sample_i;
			end
		end
	end
endmodule : adcsc_analog_model

/* tb/tb_adc_scan_result_control.sv */
// Bench for the converter control block: bus master, result reader, analog source.
// Assumes the one-wait-state bus answer of the design.
module tb_adc_scan_result_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, ack = 1'h0;
	logic rdy, err, start, done, cmpl, req;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata, lfsr = 32'h0000000C;
	logic [4:0] ch;
	logic [9:0] cdata, smp = 10'h2C3;
	logic [3:0] dly = 4'h8;
	logic [23:0] pins;
	logic [31:0] exp_q[$], ch_q[$];
	logic err_q[$];
	int error_cnt = 0, comparisons = 0, cyc = 0;
	adcsc_top dut_u (.core_clk_i(clk), .arst_n_i(rst_n), .clk_en_i(1'h1), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdata), .prdata_o(rdata),
		.pready_o(rdy), .pslverr_o(err), .conv_start_o(start), .conv_channel_o(ch),
		.conv_done_i(done), .conv_data_i(cdata), .analog_pin_en_o(pins),
		.conv_complete_o(cmpl), .dtc_req_o(req), .dtc_ack_i(ack));
	adcsc_analog_model src_u (.clk_i(clk), .start_i(start), .delay_i(dly), .sample_i(smp),
		.done_o(done), .data_o(cdata));
	initial forever #2.5 clk = ~clk;
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test
	function logic [9:0] rnd;
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[9:0];
	endfunction : rnd
	// Holds the request until pready is seen at an edge, then lets one edge pass
	// so that a following call never reassigns psel in the same time step.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		err_q.push_back(a > adcsc_pkg::ADDR_STATUS || (w && a == adcsc_pkg::ADDR_RESULT));
		psel <= 1'h1;
		pwr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (rdy !== 1'h1);
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask : apb
	// Reads every result before the next channel can overwrite it; the delay floor of 8 ensures it.
	task take(input int n);
		repeat (n) begin
			do @(posedge clk); while (cmpl !== 1'h1);
			exp_q.push_back({16'h0000, smp, 6'h00});
			smp <= rnd();
			dly <= {1'h1, lfsr[2:0]};
			chk(req, 1);
			apb(1'h0, adcsc_pkg::ADDR_RESULT, 32'h00000000);
			ack <= 1'h1;
			@(posedge clk);
			ack <= 1'h0;
		end
	endtask : take
	// Read data and channels are matched against the oldest note.
	always @(posedge clk) begin
		if (rdy === 1'h1 && !pwr) chk(rdata, exp_q.pop_front());
		if (rdy === 1'h1) chk(32'(err), 32'(err_q.pop_front()));
		if (start === 1'h1) chk(ch, ch_q.pop_front());
	end
	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			finish_test();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		for (int n = 0; n < 32; n += 8) begin
			apb(1'h1, adcsc_pkg::ADDR_PIN_CONFIG, 32'(n));
			repeat (2) @(posedge clk);
			chk(pins, n > 23 ? 32'h00FFFFFF : (32'h00000001 << n) - 1);
		end
		exp_q.push_back(32'h00000000);
		apb(1'h0, 8'h10, 32'h00000000);
		$display("pin and address test done");
		ch_q.push_back(32'h00000017);
		apb(1'h1, adcsc_pkg::ADDR_CTRL, 32'h00001701);
		take(1);
		$display("single test done");
		ch_q = {32'h00000014, 32'h00000015, 32'h00000016, 32'h00000017};
		apb(1'h1, adcsc_pkg::ADDR_CTRL, 32'h00001703);
		take(4);
		$display("scan test done");
		finish_test();
	end
endmodule : tb_adc_scan_result_control
